//--- twd_pkg.sv
// Behaviour
// - One clock line plus one shared data line
// - Debug registers reachable only over link
// - Halted device stalls peripherals and program
// - Link clock on reset pin, data on port
// - First revision needs data latch held high
// - Idle pin: open-drain, mode zero, latch one
// - Second revision ignores the data latch while halted
package twd_pkg;
    // ****************************************
    // Link register map
    // ****************************************
    localparam logic [7:0] ADDR_PART_ID   = 8'h00; // Part identifier
    localparam logic [7:0] ADDR_REV_ID    = 8'h01; // Silicon revision identifier
    localparam logic [7:0] ADDR_FP_CTL    = 8'h02; // Flash program control
    localparam logic [7:0] ADDR_FP_DATA   = 8'hb4; // Flash program data
    localparam logic [7:0] RST_FP_DATA    = 8'h00; // Flash data after reset
    localparam logic [7:0] RST_FP_CTL     = 8'h00; // Control after reset
    localparam logic [7:0] RST_SELECT     = 8'h00; // Select after reset
    localparam int         CTL_HALT_BIT   = 0;     // Halt request bit position
    localparam logic [7:0] CMD_BLOCK_READ = 8'h06; // Flash block read command
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_SYS_HZ     = 10_000_000;
    localparam int RESET_HOLD_NS  = 20_000; // Clock pin low this long means reset
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * (CLK_SYS_HZ / 1_000_000)
                                     + 999) / 1000;
    localparam int BIT_LAST       = 7;      // Last bit index of a byte
    // ****************************************
    // Link states and carriers
    // ****************************************
    typedef enum logic [2:0] {LK_IDLE, LK_INS, LK_WDATA, LK_TURN, LK_RDATA} twd_lstate_t;
    typedef struct packed {
        twd_lstate_t state;  // Frame position
        logic [2:0]  cnt;    // Bit counter
        logic [1:0]  ins;    // Bit0 write, bit1 address
        logic [7:0]  shift;  // Data shifter
        logic        oe;     // Device drives data
        logic        dout;   // Driven level
        logic [7:0]  sel;    // Register select
        logic [7:0]  ctl;    // Flash program control
        logic [7:0]  flash_program_data;  // Flash program data
        logic        ftgl;   // Toggles on each flash program data write
    } twd_link_t;
endpackage : twd_pkg

//--- twd_port.sv
module twd_port #(
    parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
    parameter logic [7:0] REV_ID  = 8'h00  // 0 first revision, else later
) (
    // System side
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Link clock pin, shared with reset input
    input  wire logic       debug_link_clock,
    // Link data pin, shared with port pin
    input  wire logic       debug_link_data_in,
    output logic            debug_link_data_out,
    output logic            debug_link_data_oe,
    // User port controls for the shared pin
    input  wire logic       port_latch_bits,
    input  wire logic       port_output_mode_bits,
    output logic            port_pin_out,
    output logic            port_pin_oe,
    // Device control
    output logic            halt_stall,
    output logic            user_reset_req,
    // Flash byte stream
    output logic [7:0]      flash_byte,
    output logic            flash_byte_strobe,
    output logic            flash_block_read
);
    // ****************************************
    // Link domain
    // ****************************************
    twd_pkg::twd_link_t lk_reg;   // Link state
    twd_pkg::twd_link_t lk_next;
    logic [2:0]         lat_reg;  // Latch synchroniser
    logic [2:0]         lat_next;
    logic               lok_reg;  // Agreed latch level
    logic               lok_next;
    logic               link_ok;

    // Register read mux, only the link sees these
    function automatic logic [7:0] read_mux(input twd_pkg::twd_link_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (s.sel)
            twd_pkg::ADDR_PART_ID: v = PART_ID;
            twd_pkg::ADDR_REV_ID:  v = REV_ID;
            twd_pkg::ADDR_FP_CTL:  v = s.ctl;
            twd_pkg::ADDR_FP_DATA: v = s.flash_program_data;
            default:               v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    // First revision blocks the link while latch is low
    // The synchroniser moves only on link edges, so a latch change
    // takes effect a few link edges later: the host gives idle pulses
    always_comb
    begin
        lat_next = {lat_reg[1:0], port_latch_bits};
        lok_next = (lat_reg[1] == lat_reg[2]) ? lat_reg[2] : lok_reg;
        link_ok  = (REV_ID == 8'h00) ? lok_reg : 1'b1;
    end

    // Frame engine, sampled on rising link clock
    always_comb
    begin
        lk_next = lk_reg;
        unique case (lk_reg.state)
            twd_pkg::LK_IDLE:
            begin
                lk_next.oe = 1'b0;
                // Start bit is a low data level
                if (link_ok && !debug_link_data_in)
                begin
                    lk_next.state = twd_pkg::LK_INS;
                    lk_next.cnt   = 3'h0;
                end
            end
            twd_pkg::LK_INS:
            begin
                lk_next.ins = {debug_link_data_in, lk_reg.ins[1]};
                lk_next.cnt = 3'h1;
                if (lk_reg.cnt == 3'h1)
                begin
                    lk_next.cnt   = 3'h0;
                    // Write when first instruction bit is high
                    lk_next.state = lk_reg.ins[1] ? twd_pkg::LK_WDATA : twd_pkg::LK_TURN;
                end
            end
            twd_pkg::LK_WDATA:
            begin
                lk_next.shift = {debug_link_data_in, lk_reg.shift[7:1]};
                lk_next.cnt   = lk_reg.cnt + 3'h1;
                if (lk_reg.cnt == 3'(twd_pkg::BIT_LAST))
                begin
                    lk_next.state = twd_pkg::LK_IDLE;
                    if (lk_reg.ins[1])
                        lk_next.sel = lk_next.shift;
                    else if (lk_reg.sel == twd_pkg::ADDR_FP_CTL)
                        lk_next.ctl = lk_next.shift;
                    else if (lk_reg.sel == twd_pkg::ADDR_FP_DATA)
                    begin
                        // Command, address or data byte for flash
                        lk_next.flash_program_data = lk_next.shift;
                        lk_next.ftgl  = ~lk_reg.ftgl;
                    end
                end
            end
            twd_pkg::LK_TURN:
            begin
                // Host has released the line by now
                // Address flag returns the select, else the selected register
                lk_next.shift = lk_reg.ins[1] ? lk_reg.sel : read_mux(lk_reg);
                lk_next.oe    = 1'b1;
                lk_next.dout  = lk_next.shift[0];
                lk_next.cnt   = 3'h0;
                lk_next.state = twd_pkg::LK_RDATA;
            end
            twd_pkg::LK_RDATA:
            begin
                lk_next.shift = {1'b0, lk_reg.shift[7:1]};
                lk_next.dout  = lk_reg.shift[1];
                lk_next.cnt   = lk_reg.cnt + 3'h1;
                if (lk_reg.cnt == 3'(twd_pkg::BIT_LAST))
                begin
                    lk_next.oe    = 1'b0;
                    lk_next.state = twd_pkg::LK_IDLE;
                end
            end
        endcase
    end

    // Link registers
    always_ff @(posedge debug_link_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lk_reg       <= '0;
            lk_reg.state <= twd_pkg::LK_IDLE;
            lk_reg.sel   <= twd_pkg::RST_SELECT;
            lk_reg.ctl   <= twd_pkg::RST_FP_CTL;
            lk_reg.flash_program_data <= twd_pkg::RST_FP_DATA;
            lat_reg      <= 3'h7;
            lok_reg      <= 1'b1;
        end
        else
        begin
            lk_reg  <= lk_next;
            lat_reg <= lat_next;
            lok_reg <= lok_next;
        end
    end

    assign debug_link_data_out = lk_reg.dout;
    assign debug_link_data_oe  = lk_reg.oe;

    // ****************************************
    // System domain
    // ****************************************
    logic [2:0]  ck_s_reg, ck_s_next;   // Clock pin synchroniser
    logic [2:0]  hl_s_reg, hl_s_next;   // Halt synchroniser
    logic [2:0]  tg_s_reg, tg_s_next;   // Flash toggle synchroniser
    logic        ck_lvl_reg, ck_lvl_next;
    logic        tg_lvl_reg, tg_lvl_next;
    logic [15:0] hold_reg, hold_next;   // Clock pin low time
    logic        halt_reg, halt_next;
    logic        urst_reg, urst_next;
    logic [7:0]  fb_reg, fb_next;
    logic        fbs_reg, fbs_next;
    logic        fbr_reg, fbr_next;
    logic        pout_reg, pout_next;
    logic        poe_reg, poe_next;

    // Crossings, pin sharing and port driver
    always_comb
    begin
        ck_s_next   = {ck_s_reg[1:0], debug_link_clock};
        hl_s_next   = {hl_s_reg[1:0], lk_reg.ctl[twd_pkg::CTL_HALT_BIT]};
        tg_s_next   = {tg_s_reg[1:0], lk_reg.ftgl};
        ck_lvl_next = (ck_s_reg[1] == ck_s_reg[2]) ? ck_s_reg[2] : ck_lvl_reg;
        tg_lvl_next = (tg_s_reg[1] == tg_s_reg[2]) ? tg_s_reg[2] : tg_lvl_reg;
        halt_next   = (hl_s_reg[1] == hl_s_reg[2]) ? hl_s_reg[2] : halt_reg;
        // Long low on the clock pin acts as user reset
        hold_next   = ck_lvl_reg ? 16'h0000 :
                      (hold_reg == 16'(twd_pkg::RESET_HOLD_CYC)) ? hold_reg : hold_reg + 16'h1;
        urst_next   = (hold_reg == 16'(twd_pkg::RESET_HOLD_CYC));
        // Captured byte is stable, toggle lags behind it
        fbs_next    = (tg_lvl_next != tg_lvl_reg);
        fb_next     = fbs_next ? lk_reg.flash_program_data : fb_reg;
        fbr_next    = fbs_next && (lk_reg.flash_program_data == twd_pkg::CMD_BLOCK_READ);
        // Open-drain pulls only when latch is zero
        pout_next   = port_latch_bits;
        poe_next    = port_output_mode_bits | ~port_latch_bits;
        // Later silicon lets the link own the pin while halted
        if (REV_ID != 8'h00 && halt_reg)
            poe_next = 1'b0;
    end

    // System registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ck_s_reg   <= 3'h7;
            hl_s_reg   <= 3'h0;
            tg_s_reg   <= 3'h0;
            ck_lvl_reg <= 1'b1;
            tg_lvl_reg <= 1'b0;
            hold_reg   <= 16'h0000;
            halt_reg   <= 1'b0;
            urst_reg   <= 1'b0;
            fb_reg     <= twd_pkg::RST_FP_DATA;
            fbs_reg    <= 1'b0;
            fbr_reg    <= 1'b0;
            pout_reg   <= 1'b1;
            poe_reg    <= 1'b0;
        end
        else
        begin
            ck_s_reg   <= ck_s_next;
            hl_s_reg   <= hl_s_next;
            tg_s_reg   <= tg_s_next;
            ck_lvl_reg <= ck_lvl_next;
            tg_lvl_reg <= tg_lvl_next;
            hold_reg   <= hold_next;
            halt_reg   <= halt_next;
            urst_reg   <= urst_next;
            fb_reg     <= fb_next;
            fbs_reg    <= fbs_next;
            fbr_reg    <= fbr_next;
            pout_reg   <= pout_next;
            poe_reg    <= poe_next;
        end
    end

    assign halt_stall        = halt_reg;
    assign user_reset_req    = urst_reg;
    assign flash_byte        = fb_reg;
    assign flash_byte_strobe = fbs_reg;
    assign flash_block_read  = fbr_reg;
    assign port_pin_out      = pout_reg;
    assign port_pin_oe       = poe_reg;
endmodule : twd_port

//--- twd_port_assertions.sv
module twd_port_assertions #(
    parameter logic [7:0] REV_ID = 8'h00
) (
    // System
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // Link pins
    input wire logic       debug_link_clock,
    input wire logic       debug_link_data_in,
    input wire logic       debug_link_data_out,
    input wire logic       debug_link_data_oe,
    // Shared port pin
    input wire logic       port_latch_bits,
    input wire logic       port_output_mode_bits,
    input wire logic       port_pin_out,
    input wire logic       port_pin_oe,
    // Device side
    input wire logic       halt_stall,
    input wire logic       user_reset_req,
    input wire logic [7:0] flash_byte,
    input wire logic       flash_byte_strobe,
    input wire logic       flash_block_read
);
    // ****************************************
    // Clock pin low time, saturating
    // ****************************************
    logic [7:0] lo_reg;
    logic [7:0] lo_next;
    always_comb
        lo_next = debug_link_clock ? 8'h00 : ((lo_reg == 8'hff) ? lo_reg : lo_reg + 8'h01);
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            lo_reg <= 8'h00;
        else
            lo_reg <= lo_next;
    // ****************************************
    // First revision link edges seen with latch low, saturating
    // ****************************************
    // Covers synchroniser lag plus one whole frame begun before it
    logic [3:0] llo_reg;
    logic [3:0] llo_next;
    always_comb
        llo_next = (REV_ID != 8'h00 || port_latch_bits) ? 4'h0 :
                   ((llo_reg == 4'hf) ? llo_reg : llo_reg + 4'h1);
    always_ff @(posedge debug_link_clock or negedge rst_n)
        if (!rst_n)
            llo_reg <= 4'h0;
        else
            llo_reg <= llo_next;
    // ****************************************
    // Checks
    // ****************************************
    a_blk_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flash_block_read == (flash_byte_strobe && flash_byte == 8'h06)) else $error("block read flag wrong");
    a_strobe_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flash_byte_strobe |=> !flash_byte_strobe) else $error("strobe longer than one cycle");
    a_pin_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (port_latch_bits && !port_output_mode_bits)[*8] |-> !port_pin_oe) else $error("idle pin driven");
    a_rev_b_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
        halt_stall[*4] |-> (REV_ID == 8'h00 || !port_pin_oe)) else $error("port drives while halted");
    a_reset_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(user_reset_req) |-> lo_reg >= 8'hc8) else $error("reset request too early");
    a_latch_refuse: assert property (@(posedge debug_link_clock) disable iff (!rst_n)
        llo_reg == 4'hf |-> !debug_link_data_oe) else $error("link answered");
    a_read_len: assert property (@(posedge debug_link_clock) disable iff (!rst_n)
        $rose(debug_link_data_oe) |-> debug_link_data_oe[*8] ##1 !debug_link_data_oe) else $error("read length");
    a_wire_match: assert property (@(posedge debug_link_clock) disable iff (!rst_n)
        debug_link_data_oe |-> debug_link_data_in == debug_link_data_out) else $error("data line fight");
endmodule : twd_port_assertions

bind twd_port twd_port_assertions #(.REV_ID(REV_ID)) u_chk (
    .clk_sys, .rst_n, .debug_link_clock, .debug_link_data_in, .debug_link_data_out,
    .debug_link_data_oe, .port_latch_bits, .port_output_mode_bits, .port_pin_out, .port_pin_oe,
    .halt_stall, .user_reset_req, .flash_byte, .flash_byte_strobe, .flash_block_read);

//--- twd_host.sv
module twd_host (
    // Link pins
    output logic      lck,
    output logic      h_oe,
    output logic      h_o,
    input  wire logic dq
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock idles high, data released
    initial
    begin
        lck = 1'b1;
        h_oe = 1'b0;
        h_o = 1'b1;
    end
    // One link period; wire sampled just before the rising edge
    task automatic bit_(input logic drv, input logic v, output logic s);
        lck = 1'b0;
        h_oe = drv;
        h_o = v;
        #62;
        s = dq;
        lck = 1'b1;
        #63;
    endtask : bit_
    // Start, write flag, address flag, a released turn bit on reads, then eight bits LSB first
    task automatic frame(input logic wr, input logic ad, input logic [7:0] d, output logic [7:0] q);
        logic s;
        bit_(1'b1, 1'b0, s);
        bit_(1'b1, wr, s);
        bit_(1'b1, ad, s);
        if (!wr)
            bit_(1'b0, 1'b1, s);
        for (int k = 0; k < 8; k++)
            bit_(wr, d[k], q[k]);
        h_oe = 1'b0;
    endtask : frame
    // Idle clock pulses with data released, no start bit
    task automatic idle(input int n);
        logic s;
        for (int k = 0; k < n; k++)
            bit_(1'b0, 1'b1, s);
    endtask : idle
    // Clock pin held low, read as reset
    task automatic hold(input int t);
        lck = 1'b0;
        #(t);
        lck = 1'b1;
    endtask : hold
endmodule : twd_host

//--- test_two_wire_debug_flash_port.sv
module test_two_wire_debug_flash_port;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Bench signals
    // ****************************************
    localparam logic [7:0] PID = 8'h3c; // Arbitrary part code
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       lat = 1'b1; // Latch high keeps the link usable
    logic       mdb = 1'b0; // Open-drain mode
    logic       d_o, d_oe, p_o, p_oe, halt, ureq, stb, blk, h_oe, h_o, lck;
    logic [7:0] fb, rd;
    logic       lat_b = 1'b1; // Latch of the second revision device
    logic       d_o_b, d_oe_b, p_o_b, p_oe_b, halt_b, h_oe_b, h_o_b, lck_b;
    int         n_fail = 0;
    int         samples_checked = 0;
    // Pull-up line: only low drivers win
    wire dq = ~(h_oe & ~h_o) & ~(d_oe & ~d_o) & ~(p_oe & ~p_o);
    wire dq_b = ~(h_oe_b & ~h_o_b) & ~(d_oe_b & ~d_o_b) & ~(p_oe_b & ~p_o_b);
    // Rows: {0, wr, ad}, value, expected read
    logic [19:0] rows [16] = '{20'h3b400, 20'h00000, 20'h2a500, 20'h000a5, 20'h100b4,
        20'h30000, {12'h000, PID}, 20'h23300, {12'h000, PID}, 20'h30100, 20'h00000,
        20'h35500, 20'h00000, 20'h30200, 20'h20100, 20'h00001};
    always #50 clk_sys = ~clk_sys;
    twd_port #(.PART_ID(PID), .REV_ID(8'h00)) DUT (
        .clk_sys, .rst_n, .debug_link_clock(lck), .debug_link_data_in(dq),
        .debug_link_data_out(d_o), .debug_link_data_oe(d_oe), .port_latch_bits(lat),
        .port_output_mode_bits(mdb), .port_pin_out(p_o), .port_pin_oe(p_oe), .halt_stall(halt),
        .user_reset_req(ureq), .flash_byte(fb), .flash_byte_strobe(stb), .flash_block_read(blk));
    twd_host HOST (.lck, .h_oe, .h_o, .dq);
    // Second revision device on a link of its own
    twd_port #(.PART_ID(PID), .REV_ID(8'h01)) DUT_B (
        .clk_sys, .rst_n, .debug_link_clock(lck_b), .debug_link_data_in(dq_b),
        .debug_link_data_out(d_o_b), .debug_link_data_oe(d_oe_b), .port_latch_bits(lat_b),
        .port_output_mode_bits(mdb), .port_pin_out(p_o_b), .port_pin_oe(p_oe_b),
        .halt_stall(halt_b), .user_reset_req(), .flash_byte(), .flash_byte_strobe(),
        .flash_block_read());
    twd_host HOST_B (.lck(lck_b), .h_oe(h_oe_b), .h_o(h_o_b), .dq(dq_b));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Port inputs move just after an edge, then let the synchronisers settle;
    // idle link pulses carry the latch into the link domain
    task automatic pins(input logic l, input logic m);
        @(posedge clk_sys);
        #5;
        lat = l;
        mdb = m;
        repeat (10) @(posedge clk_sys);
        #5;
        HOST.idle(6);
    endtask : pins
    // Flash data write, bounded wait for its one-cycle strobe
    task automatic flash(input logic [7:0] d);
        int k;
        HOST.frame(1'b1, 1'b0, d, rd);
        for (k = 0; k < 40 && stb !== 1'b1; k++)
            @(posedge clk_sys) #1;
        chk("flash strobe", {7'h0, stb}, 8'h01);
        chk("flash byte", fb, d);
        chk("block read", {7'h0, blk}, {7'h0, d == 8'h06});
    endtask : flash
    task automatic close_out;
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    // Watchdog
    initial
    begin
        #3_000_000;
        n_fail++;
        close_out;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #5;
        rst_n = 1'b1;
        @(posedge clk_sys) #5;
        chk("reset pins", {halt, p_o, p_oe, d_oe, ureq, stb, blk, 1'b0}, 8'h40);
        foreach (rows[i])
        begin
            HOST.frame(rows[i][17], rows[i][16], rows[i][15:8], rd);
            if (!rows[i][17])
                chk("read", rd, rows[i][7:0]);
        end
        repeat (10) @(posedge clk_sys);
        chk("halt on", {7'h0, halt}, 8'h01);
        HOST.frame(1'b1, 1'b1, 8'hb4, rd);
        flash(8'h06);
        // Zero data keeps a stray answer equal to the held-low line
        flash(8'h00);
        // Latch low: port drives the line, link must refuse
        pins(1'b0, 1'b0);
        chk("port low", {6'h0, p_o, p_oe}, 8'h01);
        HOST.frame(1'b1, 1'b0, 8'hff, rd);
        pins(1'b1, 1'b0);
        HOST.frame(1'b0, 1'b0, 8'h00, rd);
        chk("refused", rd, 8'h00);
        pins(1'b1, 1'b1);
        chk("push pull", {7'h0, p_oe}, 8'h01);
        pins(1'b1, 1'b0);
        HOST.frame(1'b1, 1'b1, 8'h02, rd);
        HOST.frame(1'b1, 1'b0, 8'h00, rd);
        repeat (10) @(posedge clk_sys);
        chk("halt off", {7'h0, halt}, 8'h00);
        // Clock pin held low acts as reset request
        fork
            HOST.hold(25_000);
            #24_000 chk("reset req", {7'h0, ureq}, 8'h01);
        join
        repeat (10) @(posedge clk_sys);
        chk("reset req off", {7'h0, ureq}, 8'h00);
        // Second revision: halted, latch low, link still works
        HOST_B.frame(1'b1, 1'b1, 8'h02, rd);
        HOST_B.frame(1'b1, 1'b0, 8'h01, rd);
        repeat (10) @(posedge clk_sys);
        #5;
        lat_b = 1'b0;
        repeat (10) @(posedge clk_sys);
        #5;
        chk("halt b", {7'h0, halt_b}, 8'h01);
        chk("rev b pin free", {7'h0, p_oe_b}, 8'h00);
        HOST_B.frame(1'b1, 1'b1, 8'hb4, rd);
        HOST_B.frame(1'b1, 1'b0, 8'h5a, rd);
        HOST_B.frame(1'b0, 1'b0, 8'h00, rd);
        chk("rev b read", rd, 8'h5a);
        close_out;
    end
endmodule : test_two_wire_debug_flash_port
